// >>> audio_codec_model.sv
`timescale 1ns/100ps
module audio_codec_model (
	// Serial lines toward the port
	output logic sck,
	output logic ws,
	output logic sd,
	// Serial data from the port
	input wire logic dut_sd
);
	logic [15:0] words[$];
	logic [15:0] heard[$];
	logic [15:0] shift_in;

	// Clock idles low and stands still outside frames.
	initial
	begin
		sck = 1'b0;
		ws = 1'b0;
		sd = 1'b0;
	end

	// Plays words alternately right then left, one slot of delay after each channel change.
	task automatic play(input int half_ns);
		int n;
		int t;
		n = words.size();
		heard.delete();
		ws = 1'b1;
		for (int s = -1; s <= 16 * n; s++)
		begin
			#half_ns sck = 1'b1;
			#half_ns sck = 1'b0;
			shift_in = {shift_in[14:0], dut_sd};
			if (s >= 0 && s < 16 * n && s % 16 == 15)
				heard.push_back(shift_in);
			t = s + 1;
			// Released data line shows the inverse of its last level.
			sd = (t < 16 * n) ? words[t / 16][15 - t % 16] : ~sd;
			ws = ((t + 1) / 16 < n) ? ~1'((t + 1) / 16) : 1'b0;
		end
	endtask
endmodule // audio_codec_model

// >>> audio_port_monitor.sv
`timescale 1ns/100ps
module audio_port_monitor (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Data memory access
	input wire logic [15:0] addr,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] write_data,
	input wire logic [7:0] read_data,
	// Trigger events
	input wire logic sof_event,
	input wire logic pin_change_event,
	input wire logic timer_compare_event,
	// Serial pins
	input wire audio_port_pkg::pins_t [1:0] pin_in,
	input wire audio_port_pkg::pins_t [1:0] pin_out,
	input wire audio_port_pkg::pins_t [1:0] pin_oe,
	// Processor side status
	input wire logic port_irq,
	input wire logic tx_buffer_ready
);
	audio_port_pkg::config_a_t cfg_a;
	audio_port_pkg::config_a_t cfg_a_d;
	audio_port_pkg::config_b_t cfg_b;
	audio_port_pkg::config_b_t cfg_b_d;
	wire logic hit_a;
	wire logic hit_b;
	wire logic settled;

	// Decoding of configuration writes; settled means no change in the last cycle.
	assign hit_a = write_strobe && addr == audio_port_pkg::ADDR_CONFIG_A;
	assign hit_b = write_strobe && addr == audio_port_pkg::ADDR_CONFIG_B;
	assign settled = (cfg_a == cfg_a_d) && (cfg_b == cfg_b_d);

	// Shadow copies of both configuration registers, and their values one cycle back.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_a <= audio_port_pkg::config_a_t'(audio_port_pkg::CONFIG_A_RESET);
			cfg_b <= audio_port_pkg::config_b_t'(audio_port_pkg::CONFIG_B_RESET);
			cfg_a_d <= audio_port_pkg::config_a_t'(audio_port_pkg::CONFIG_A_RESET);
			cfg_b_d <= audio_port_pkg::config_b_t'(audio_port_pkg::CONFIG_B_RESET);
		end
		else
		begin
			cfg_a <= hit_a ? audio_port_pkg::config_a_t'(write_data) : cfg_a;
			cfg_b <= hit_b ? audio_port_pkg::config_b_t'(write_data) : cfg_b;
			cfg_a_d <= cfg_a;
			cfg_b_d <= cfg_b;
		end
	end

	default clocking main_cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// A write and a read of the high data byte.
	sequence s_high_write;
		write_strobe && addr == audio_port_pkg::ADDR_DATA_HIGH;
	endsequence
	sequence s_high_read;
		read_strobe && !write_strobe && addr == audio_port_pkg::ADDR_DATA_HIGH;
	endsequence

	AST_RESET_QUIET: assert property ($fell(rst) |-> pin_oe == '0 && !port_irq && tx_buffer_ready)
		else $error("outputs not quiet after reset");
	AST_OE_DISABLED: assert property (settled && !cfg_a.port_enable |-> pin_oe == '0)
		else $error("pin driven while port disabled");
	AST_OE_LOCATION: assert property (settled |-> pin_oe[~cfg_b.pin_location_sel] == '0)
		else $error("unselected pin location driven");
	AST_OE_MASTER: assert property (settled && cfg_a.port_enable |->
		pin_oe[cfg_b.pin_location_sel].sck == cfg_a.master_clock
		&& pin_oe[cfg_b.pin_location_sel].ws == cfg_a.master_clock)
		else $error("clock pin direction does not follow clock source");
	AST_PINS_STILL: assert property (settled && $past(settled) && !cfg_a.port_enable |-> $stable(pin_out))
		else $error("serial pins moved while port disabled");
	AST_READ_CONFIG_A: assert property (read_strobe && !write_strobe && addr == audio_port_pkg::ADDR_CONFIG_A
		|=> read_data == $past(cfg_a))
		else $error("first configuration register read wrong");
	AST_READ_CONFIG_B: assert property (read_strobe && !write_strobe && addr == audio_port_pkg::ADDR_CONFIG_B
		|=> read_data == $past(cfg_b))
		else $error("second configuration register read wrong");
	AST_IRQ_GATED: assert property (!cfg_a.tx_irq_enable && !cfg_a.rx_irq_enable |-> !port_irq)
		else $error("interrupt raised with both enables clear");
	AST_TX_FLAG_CLEAR: assert property (s_high_write ##0 (settled && cfg_a.tx_irq_enable
		&& !cfg_a.rx_irq_enable && !cfg_a.port_enable) |=> !port_irq)
		else $error("high byte write left transmit request pending");
	AST_RX_FLAG_CLEAR: assert property (s_high_read ##0 (settled && cfg_a.rx_irq_enable
		&& !cfg_a.tx_irq_enable && !cfg_a.port_enable) |=> !port_irq)
		else $error("high byte read left receive request pending");
endmodule // audio_port_monitor

bind audio_serial_port audio_port_monitor audio_port_monitor_i (.ref_clk(ref_clk), .rst(rst), .addr(addr),
	.write_strobe(write_strobe), .read_strobe(read_strobe), .write_data(write_data), .read_data(read_data),
	.sof_event(sof_event), .pin_change_event(pin_change_event), .timer_compare_event(timer_compare_event),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .port_irq(port_irq), .tx_buffer_ready(tx_buffer_ready));

// >>> audio_port_pkg.sv
// Notes on behaviour
// (R1) Expand written high byte, transmit or standalone.
// (R2) Compress received sample, or standalone written pair.
// (R3) Mono transmit repeats sample in both channels.
// (R4) Mono receive drops right-channel words.
// (R5) Clock-source bit: generate or take clock pins.
// (R6) Serial port runs only when enabled; off after reset.
// (R7) Software keeps port disabled for standalone mu-law.
// (R8) Sample length minus one, reset 0x0F.
// (R9) Trigger select copies and clears word counter.
// (R10) Pin-location bit picks one of two mappings.
// (R11) Repeated high write clears transmit low byte.
// (R12) High byte read clears receive request flag.
// (R13) High byte write clears transmit request flag.
// (R14) Data bytes reset zero, form 16-bit register.
// (R15) Enables gate request flags onto port interrupt.
// (R16) Standalone mu-law result ready one cycle later.
// (R17) Long master words padded with low zeros.
// (R18) Ten-bit word-select counter copied and cleared.
package audio_port_pkg;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_CONFIG_A = 16'hdf40;
	localparam logic [15:0] ADDR_CONFIG_B = 16'hdf41;
	localparam logic [15:0] ADDR_DATA_LOW = 16'hdf42;
	localparam logic [15:0] ADDR_DATA_HIGH = 16'hdf43;
	localparam logic [15:0] ADDR_WORD_COUNT = 16'hdf44;
	localparam logic [15:0] ADDR_STATUS = 16'hdf45;
	localparam logic [7:0] CONFIG_A_RESET = 8'h00;
	localparam logic [7:0] CONFIG_B_RESET = 8'h78;
	localparam logic [7:0] DATA_BYTE_RESET = 8'h00;
	localparam logic [9:0] WORD_COUNT_MAX = 10'h3ff;
	localparam logic [4:0] SAMPLE_BITS = 5'h10;

	// ------------------------------------------------------------
	// Timing of the generated serial clock
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SCK_HALF_NS = 80;
	localparam int SCK_HALF_CYCLES = (SCK_HALF_NS / CLK_PERIOD_NS < 1) ? 1 : SCK_HALF_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Mu-law constants
	// ------------------------------------------------------------
	localparam logic [15:0] MULAW_BIAS = 16'h0084;
	localparam logic [15:0] MULAW_CLIP = 16'h7f7b;

	// ------------------------------------------------------------
	// Field layouts and encodings
	// ------------------------------------------------------------
	typedef struct packed {
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic mulaw_expand_sel;
		logic mulaw_compress_sel;
		logic tx_single_channel;
		logic rx_single_channel;
		logic master_clock;
		logic port_enable;
	} config_a_t;

	typedef enum logic [1:0] {TRIG_NONE, TRIG_FRAME_START, TRIG_PIN_CHANGE, TRIG_TIMER} trigger_t;

	typedef struct packed {
		logic [4:0] word_len_m1;
		trigger_t count_trigger_sel;
		logic pin_location_sel;
	} config_b_t;

	typedef struct packed {
		logic sck;
		logic ws;
		logic sd;
	} pins_t;

	// Compresses a signed 16-bit sample into an 8-bit mu-law code.
	function automatic logic [7:0] mulaw_compress(input logic [15:0] x);
		logic [15:0] mag;
		logic [2:0] seg;
		logic [3:0] mant;
		mag = x[15] ? 16'(~x + 16'h0001) : x;
		if (mag > MULAW_CLIP)
		begin
			mag = MULAW_CLIP;
		end
		mag = 16'(mag + MULAW_BIAS);
		seg = 3'h0;
		for (int i = 1; i < 8; i++)
		begin
			if (mag[i + 7])
			begin
				seg = 3'(i);
			end
		end
		mant = 4'(mag >> ({1'b0, seg} + 4'h3));
		return ~{x[15], seg, mant};
	endfunction

	// Expands an 8-bit mu-law code into a signed 16-bit sample.
	function automatic logic [15:0] mulaw_expand(input logic [7:0] code);
		logic [7:0] n;
		logic [15:0] t;
		n = ~code;
		t = 16'((({12'h000, n[3:0]} << 3) + MULAW_BIAS) << n[6:4]);
		t = 16'(t - MULAW_BIAS);
		return n[7] ? 16'(~t + 16'h0001) : t;
	endfunction

endpackage

// >>> audio_serial_port.sv
`timescale 1ns/100ps
module audio_serial_port #(
	parameter int SCK_HALF = audio_port_pkg::SCK_HALF_CYCLES,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Data memory access
	input wire logic [15:0] addr,
	input wire logic write_strobe,
	input wire logic read_strobe,
	input wire logic [7:0] write_data,
	output logic [7:0] read_data,
	// Word counter trigger events
	input wire logic sof_event,
	input wire logic pin_change_event,
	input wire logic timer_compare_event,
	// Serial pins, two alternative locations
	input wire audio_port_pkg::pins_t [1:0] pin_in,
	output audio_port_pkg::pins_t [1:0] pin_out,
	output audio_port_pkg::pins_t [1:0] pin_oe,
	// Processor side status
	output logic port_irq,
	output logic tx_buffer_ready
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int FILL_W = $clog2(DEPTH + 1);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	audio_port_pkg::config_a_t cfg_a;
	audio_port_pkg::config_b_t cfg_b;
	logic [15:0] data_reg;
	logic low_written;
	logic tx_request_flag;
	logic rx_request_flag;
	logic [9:0] word_count;
	logic [9:0] count_copy;

	// ------------------------------------------------------------
	// Serial state
	// ------------------------------------------------------------
	audio_port_pkg::pins_t pin_meta;
	audio_port_pkg::pins_t pin_sync;
	logic sck_last;
	logic ws_seen;
	logic ws_rise;
	logic ws_prev;
	logic gen_sck;
	logic gen_ws;
	logic [15:0] div_cnt;
	logic [4:0] gen_bits;
	logic [15:0] tx_shift;
	logic [15:0] tx_hold;
	logic sd_drive;
	logic [15:0] rx_shift;
	logic [4:0] rx_bits;
	logic [15:0] buf_mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [FILL_W-1:0] fill;

	// ------------------------------------------------------------
	// Address decode and register access
	// ------------------------------------------------------------
	wire logic write_cfg_a = write_strobe && addr == audio_port_pkg::ADDR_CONFIG_A;
	wire logic write_cfg_b = write_strobe && addr == audio_port_pkg::ADDR_CONFIG_B;
	wire logic write_low = write_strobe && addr == audio_port_pkg::ADDR_DATA_LOW;
	wire logic write_high = write_strobe && addr == audio_port_pkg::ADDR_DATA_HIGH;
	wire logic write_count = write_strobe && addr == audio_port_pkg::ADDR_WORD_COUNT;
	wire logic read_high = read_strobe && addr == audio_port_pkg::ADDR_DATA_HIGH;
	wire logic enabled = cfg_a.port_enable; // [R6]
	wire logic master = cfg_a.master_clock;
	wire logic expand_sel = cfg_a.mulaw_expand_sel;
	wire logic compress_sel = cfg_a.mulaw_compress_sel;

	// Read selection; unmapped addresses read as zero.
	wire logic [7:0] status_view = {4'h0, tx_request_flag, rx_request_flag, count_copy[9:8]};
	wire logic [7:0] read_mux =
		(addr == audio_port_pkg::ADDR_CONFIG_A) ? cfg_a :
		(addr == audio_port_pkg::ADDR_CONFIG_B) ? cfg_b :
		(addr == audio_port_pkg::ADDR_DATA_LOW) ? data_reg[7:0] :
		(addr == audio_port_pkg::ADDR_DATA_HIGH) ? data_reg[15:8] :
		(addr == audio_port_pkg::ADDR_WORD_COUNT) ? count_copy[7:0] :
		(addr == audio_port_pkg::ADDR_STATUS) ? status_view : 8'h00;

	// ------------------------------------------------------------
	// Serial clock and word select selection
	// ------------------------------------------------------------
	wire audio_port_pkg::pins_t pin_sel = pin_in[cfg_b.pin_location_sel]; // [R10]
	wire logic act_sck = master ? gen_sck : pin_sync.sck; // [R5]
	wire logic act_ws = master ? gen_ws : pin_sync.ws; // [R5]
	wire logic sck_fall = sck_last && !act_sck;
	wire logic sck_rise = !sck_last && act_sck;
	wire logic word_start = enabled && sck_fall && ws_rise != ws_prev; // [R6]
	wire logic div_wrap = div_cnt == 16'(SCK_HALF - 1);

	// ------------------------------------------------------------
	// Transmit buffer and word selection
	// ------------------------------------------------------------
	wire logic buf_valid = fill != '0;
	assign tx_buffer_ready = fill != FILL_W'(DEPTH);
	wire logic pop_req = word_start && (!ws_rise || !cfg_a.tx_single_channel); // [R3]
	wire logic pop = pop_req && buf_valid;
	wire logic [7:0] low_value = low_written ? data_reg[7:0] : 8'h00; // [R11]
	wire logic [15:0] written_word = {write_data, low_value}; // [R14]
	wire logic [15:0] expanded = audio_port_pkg::mulaw_expand(write_data);
	wire logic [15:0] tx_word = expand_sel ? expanded : written_word; // [R1]
	wire logic push = write_high && enabled && tx_buffer_ready;
	wire logic [15:0] next_tx_word =
		pop ? buf_mem[rd_ptr] :
		(cfg_a.tx_single_channel && ws_rise) ? tx_hold : 16'h0000; // [R3]

	// ------------------------------------------------------------
	// Receive word alignment and data register update
	// ------------------------------------------------------------
	wire logic [15:0] rx_aligned = 16'(rx_shift << (audio_port_pkg::SAMPLE_BITS - rx_bits));
	wire logic [15:0] rx_value = compress_sel ? {audio_port_pkg::mulaw_compress(rx_aligned), 8'h00} : rx_aligned; // [R2]
	wire logic rx_load = word_start && rx_bits != 5'h00 && !(cfg_a.rx_single_channel && ws_prev); // [R4]
	wire logic [15:0] standalone =
		(expand_sel && !compress_sel) ? expanded : // [R1] [R16]
		(compress_sel && !expand_sel) ? {audio_port_pkg::mulaw_compress(written_word), low_value} : // [R2] [R16]
		written_word;
	wire logic [15:0] next_data =
		write_high ? (enabled ? written_word : standalone) :
		write_low ? {data_reg[15:8], write_data} :
		rx_load ? rx_value : data_reg;

	// Request flags: a hardware set wins over the clearing access.
	wire logic next_tx_flag = pop || (tx_request_flag && !write_high); // [R13]
	wire logic next_rx_flag = rx_load || (rx_request_flag && !read_high); // [R12]
	assign port_irq = (tx_request_flag && cfg_a.tx_irq_enable) || (rx_request_flag && cfg_a.rx_irq_enable); // [R15]

	// ------------------------------------------------------------
	// Word counter trigger decode
	// ------------------------------------------------------------
	wire logic [3:0] trig_vec = {timer_compare_event, pin_change_event, sof_event, 1'b0};
	wire logic count_clear = trig_vec[cfg_b.count_trigger_sel] || write_count; // [R9] [R18]
	wire logic ws_edge = act_ws != ws_seen;

	// ------------------------------------------------------------
	// Configuration registers and read data
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_a <= audio_port_pkg::CONFIG_A_RESET; // [R6]
			cfg_b <= audio_port_pkg::CONFIG_B_RESET; // [R8]
			read_data <= 8'h00;
		end
		else
		begin
			if (write_cfg_a)
				cfg_a <= write_data;
			if (write_cfg_b)
				cfg_b <= write_data;
			if (read_strobe)
				read_data <= read_mux;
		end
	end

	// Data register pair and request flags.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			data_reg <= {audio_port_pkg::DATA_BYTE_RESET, audio_port_pkg::DATA_BYTE_RESET}; // [R14]
			low_written <= 1'b0;
			tx_request_flag <= 1'b0;
			rx_request_flag <= 1'b0;
		end
		else
		begin
			data_reg <= next_data;
			low_written <= write_low || (low_written && !write_high); // [R11]
			tx_request_flag <= next_tx_flag;
			rx_request_flag <= next_rx_flag;
		end
	end

	// Word counter counts word-select transitions and saturates at its top.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			word_count <= 10'h000;
			count_copy <= 10'h000;
			ws_seen <= 1'b0;
		end
		else
		begin
			ws_seen <= act_ws;
			if (count_clear)
			begin
				count_copy <= word_count; // [R18]
				word_count <= 10'h000;
			end
			else if (ws_edge && word_count != audio_port_pkg::WORD_COUNT_MAX)
				word_count <= 10'(word_count + 10'h001); // [R18]
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers and edge tracking
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_meta <= '0;
			pin_sync <= '0;
			sck_last <= 1'b0;
			ws_rise <= 1'b0;
		end
		else
		begin
			pin_meta <= pin_sel;
			pin_sync <= pin_meta;
			sck_last <= act_sck;
			// Word select is taken at the rising edge, so a word starts one bit after it changes.
			if (sck_rise)
				ws_rise <= act_ws;
		end
	end

	// Master mode clock and word-select generator.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_cnt <= 16'h0000;
			gen_sck <= 1'b0;
			gen_ws <= 1'b0;
			gen_bits <= 5'h00;
		end
		else if (!(enabled && master))
		begin
			div_cnt <= 16'h0000;
			gen_sck <= 1'b0;
			gen_ws <= 1'b0;
			gen_bits <= 5'h00;
		end
		else if (div_wrap)
		begin
			div_cnt <= 16'h0000;
			gen_sck <= !gen_sck; // [R5]
			if (gen_sck)
			begin
				gen_bits <= (gen_bits == cfg_b.word_len_m1) ? 5'h00 : 5'(gen_bits + 5'h01); // [R8]
				if (gen_bits == cfg_b.word_len_m1)
					gen_ws <= !gen_ws; // [R8]
			end
		end
		else
			div_cnt <= 16'(div_cnt + 16'h0001);
	end

	// ------------------------------------------------------------
	// Serial transmit and receive shifters
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ws_prev <= 1'b0;
			tx_shift <= 16'h0000;
			tx_hold <= 16'h0000;
			sd_drive <= 1'b0;
			rx_shift <= 16'h0000;
			rx_bits <= 5'h00;
		end
		else if (word_start)
		begin
			ws_prev <= ws_rise;
			tx_hold <= next_tx_word; // [R3]
			sd_drive <= next_tx_word[15];
			tx_shift <= {next_tx_word[14:0], 1'b0};
			rx_bits <= 5'h00;
		end
		else if (enabled && sck_fall)
		begin
			ws_prev <= ws_rise;
			sd_drive <= tx_shift[15];
			tx_shift <= {tx_shift[14:0], 1'b0}; // [R17]
		end
		else if (enabled && sck_rise && rx_bits != audio_port_pkg::SAMPLE_BITS)
		begin
			rx_shift <= {rx_shift[14:0], pin_sync.sd};
			rx_bits <= 5'(rx_bits + 5'h01);
		end
	end

	// Two-entry transmit buffer between the data register and the shifter.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(wr_ptr + 1'b1);
			if (pop)
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(rd_ptr + 1'b1);
			if (push && !pop)
				fill <= FILL_W'(fill + 1'b1);
			else if (pop && !push)
				fill <= FILL_W'(fill - 1'b1);
		end
	end

	// Buffer storage is written without reset; only the pointers and the fill count carry state.
	always_ff @(posedge ref_clk)
	begin
		if (push)
			buf_mem[wr_ptr] <= tx_word; // [R13]
	end

	// ------------------------------------------------------------
	// Pin drivers for both locations
	// ------------------------------------------------------------
	generate
		for (genvar k = 0; k < 2; k++)
		begin : g_pins
			wire logic here = enabled && cfg_b.pin_location_sel == 1'(k); // [R10]
			assign pin_out[k] = '{sck: gen_sck, ws: gen_ws, sd: sd_drive};
			assign pin_oe[k] = '{sck: here && master, ws: here && master, sd: here}; // [R5]
		end
	endgenerate

endmodule // audio_serial_port

// >>> test_audio_serial_port.sv
`timescale 1ns/100ps
module test_audio_serial_port;
	logic ref_clk;
	logic rst;
	logic [15:0] addr;
	logic write_strobe;
	logic read_strobe;
	logic [7:0] write_data;
	logic [7:0] read_data;
	logic sof_event;
	logic pin_change_event;
	logic timer_compare_event;
	audio_port_pkg::pins_t [1:0] pin_in;
	audio_port_pkg::pins_t [1:0] pin_out;
	audio_port_pkg::pins_t [1:0] pin_oe;
	logic port_irq;
	logic tx_buffer_ready;
	logic codec_sck;
	logic codec_ws;
	logic codec_sd;
	int errors;
	int checks;
	int cycles;

	// The codec sits on the first pin location; the second is left idle.
	assign pin_in[0] = {codec_sck, codec_ws, codec_sd};
	assign pin_in[1] = 3'h0;

	audio_serial_port audio_serial_port_i (.ref_clk(ref_clk), .rst(rst), .addr(addr), .write_strobe(write_strobe),
		.read_strobe(read_strobe), .write_data(write_data), .read_data(read_data), .sof_event(sof_event),
		.pin_change_event(pin_change_event), .timer_compare_event(timer_compare_event), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .port_irq(port_irq), .tx_buffer_ready(tx_buffer_ready));
	audio_codec_model audio_codec_model_i (.sck(codec_sck), .ws(codec_ws), .sd(codec_sd), .dut_sd(pin_out[0].sd));

	// Free-running system clock.
	always #10 ref_clk = ~ref_clk;

	// Cuts a hung run short.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One register access: strobe for a single cycle, just after the edge.
	task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 addr = a;
		write_data = d;
		write_strobe = wr;
		read_strobe = !wr;
		@(posedge ref_clk);
		#1 write_strobe = 1'b0;
		read_strobe = 1'b0;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		access(1'b1, a, d);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		access(1'b0, a, 8'h00);
		check($sformatf("read %h", a), {8'h00, exp}, {8'h00, read_data});
	endtask

	task automatic done(input string name);
		$display("test %s finished", name);
	endtask

	// Main sequence.
	initial
	begin
		logic [7:0] v;
		ref_clk = 1'b0;
		rst = 1'b1;
		addr = 16'h0000;
		write_strobe = 1'b0;
		read_strobe = 1'b0;
		write_data = 8'h00;
		sof_event = 1'b0;
		pin_change_event = 1'b0;
		timer_compare_event = 1'b0;
		errors = 0;
		checks = 0;
		cycles = 0;
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'b0;
		rd(16'hdf40, 8'h00);
		rd(16'hdf41, 8'h78);
		rd(16'hdf42, 8'h00);
		rd(16'hdf43, 8'h00);
		rd(16'hdf50, 8'h00);
		done("reset");
		for (int k = 0; k < 4; k++)
		begin
			v = {5'(k + 8), 2'(k), 1'(k)};
			wr(16'hdf41, v);
			rd(16'hdf41, v);
		end
		wr(16'hdf40, 8'hfe);
		rd(16'hdf40, 8'hfe);
		done("config");
		wr(16'hdf40, 8'h80);
		wr(16'hdf42, 8'h34);
		wr(16'hdf43, 8'h12);
		rd(16'hdf43, 8'h12);
		rd(16'hdf42, 8'h34);
		wr(16'hdf43, 8'h56);
		rd(16'hdf42, 8'h00);
		rd(16'hdf43, 8'h56);
		done("data");
		wr(16'hdf40, 8'h20);
		wr(16'hdf43, 8'h80);
		rd(16'hdf43, 8'h7d);
		rd(16'hdf42, 8'h7c);
		wr(16'hdf43, 8'h00);
		rd(16'hdf43, 8'h82);
		rd(16'hdf42, 8'h84);
		wr(16'hdf40, 8'h10);
		wr(16'hdf42, 8'h00);
		wr(16'hdf43, 8'h7f);
		rd(16'hdf43, 8'h80);
		wr(16'hdf43, 8'h00);
		rd(16'hdf43, 8'hff);
		done("mulaw");
		wr(16'hdf41, 8'h7c);
		wr(16'hdf40, 8'h45);
		check("tx_buffer_ready", 16'h0001, {15'h0000, tx_buffer_ready});
		wr(16'hdf42, 8'hc3);
		wr(16'hdf43, 8'ha5);
		wr(16'hdf42, 8'h3c);
		wr(16'hdf43, 8'h5a);
		check("tx_buffer_ready", 16'h0000, {15'h0000, tx_buffer_ready});
		wr(16'hdf44, 8'h00);
		audio_codec_model_i.words = '{16'hbeef, 16'h1234, 16'habcd, 16'h1234, 16'habcd};
		audio_codec_model_i.play(80);
		check("first word sent", 16'ha5c3, audio_codec_model_i.heard[0]);
		check("second word sent", 16'h5a3c, audio_codec_model_i.heard[1]);
		check("empty buffer word", 16'h0000, audio_codec_model_i.heard[2]);
		check("tx_buffer_ready", 16'h0001, {15'h0000, tx_buffer_ready});
		check("port_irq", 16'h0001, {15'h0000, port_irq});
		rd(16'hdf45, 8'h0c);
		@(posedge ref_clk);
		#1 sof_event = 1'b1;
		timer_compare_event = 1'b1;
		@(posedge ref_clk);
		#1 sof_event = 1'b0;
		timer_compare_event = 1'b0;
		pin_change_event = 1'b1;
		@(posedge ref_clk);
		#1 pin_change_event = 1'b0;
		rd(16'hdf44, 8'h06);
		wr(16'hdf40, 8'h40);
		rd(16'hdf43, 8'h12);
		rd(16'hdf42, 8'h34);
		check("port_irq", 16'h0000, {15'h0000, port_irq});
		rd(16'hdf45, 8'h08);
		wr(16'hdf40, 8'h80);
		check("port_irq", 16'h0001, {15'h0000, port_irq});
		wr(16'hdf43, 8'h00);
		check("port_irq", 16'h0000, {15'h0000, port_irq});
		done("slave");
		give_verdict();
	end
endmodule // test_audio_serial_port
